// ==== hw/lgsc_defs.svh ====
`ifndef LGSC_DEFS_SVH
`define LGSC_DEFS_SVH

// =====================================================
// register offsets
`define LGSC_PATTERN_CONFIGURATION_ADDR 8'h80
`define LGSC_GROUP_BRIGHTNESS_HIGH_ADDR 8'h86
`define LGSC_GROUP_BRIGHTNESS_LOW_ADDR 8'h87
`define LGSC_RED_GROUP_SCALING_ADDR 8'h88
`define LGSC_GREEN_GROUP_SCALING_ADDR 8'h89
`define LGSC_BLUE_GROUP_SCALING_ADDR 8'h8a
`define LGSC_GROUP_CONFIGURATION_ADDR 8'h8b

// =====================================================
// field positions
`define LGSC_PATTERN_ENABLE_BIT 0
`define LGSC_GROUP_SCALING_DISABLE_BIT 6
`define LGSC_GROUP_CFG_WMASK 8'hc7

// =====================================================
// reset values
`define LGSC_SCALING_RST 8'h00
`define LGSC_GROUP_CFG_RST 8'h00
`define LGSC_BRIGHT_RST 8'h00
`define LGSC_PATTERN_CFG_RST 8'h00

`endif

// ==== hw/lgsc_pkg.sv ====
package lgsc_pkg;
  typedef logic [7:0] lgsc_byte_t;
  typedef logic [11:0] lgsc_bright_t;
  typedef enum logic [1:0] {
    LGSC_INDIVIDUAL,
    LGSC_GROUP,
    LGSC_BREATH
  } lgsc_mode_e;
endpackage

// ==== hw/lgsc_channel_select.sv ====
`timescale 1ns/1ps

// per-channel selection of scaling, brightness and mode
module lgsc_channel_select
  import lgsc_pkg::*;
(
  // configuration
  input wire logic group_en,
  input wire logic pattern_en,
  input wire logic scaling_dis,
  input wire lgsc_pkg::lgsc_byte_t shared_scaling,
  input wire lgsc_pkg::lgsc_bright_t group_bright,
  // own settings
  input wire lgsc_pkg::lgsc_byte_t own_scaling,
  input wire lgsc_pkg::lgsc_bright_t own_bright,
  // result
  output lgsc_pkg::lgsc_mode_e mode,
  output lgsc_pkg::lgsc_byte_t scaling,
  output lgsc_pkg::lgsc_bright_t bright
);
  always_comb begin
    if (!group_en) begin
      mode = LGSC_INDIVIDUAL;
    end else if (pattern_en) begin
      mode = LGSC_BREATH;
    end else begin
      mode = LGSC_GROUP;
    end
    if (group_en && !scaling_dis) begin
      scaling = shared_scaling;
    end else begin
      scaling = own_scaling;
    end
    if (group_en && !pattern_en) begin
      bright = group_bright;
    end else begin
      bright = own_bright;
    end
  end
endmodule

// ==== hw/lgsc_top.sv ====
`timescale 1ns/1ps
`include "lgsc_defs.svh"

// Notes on behaviour
// - channels 1, 4 and 7 in group mode use the red group scaling.
// - channels 2, 5 and 8 in group mode use the green group scaling.
// - channels 3, 6 and 9 in group mode use the blue group scaling.
// - with scaling disable clear, grouped channels use shared scaling.
// - with scaling disable set, grouped channels use their own scaling.
// - with pattern off, enable bits 2:0 put triples in group mode.
// - with pattern on, enable bits 2:0 put triples under breathing.
// - pattern enable bit 0 picks group when 0 and pattern when 1.
// - with pattern off, the high brightness byte gives the upper nibble.
// - with pattern on, high and low bytes are max and min fade levels.
module lgsc_top
  import lgsc_pkg::*;
#(
  parameter int CHANNELS = 9
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register access from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire lgsc_pkg::lgsc_byte_t reg_addr,
  input wire lgsc_pkg::lgsc_byte_t reg_wdata,
  output lgsc_pkg::lgsc_byte_t reg_rdata,
  // per-channel individual settings
  input wire logic [CHANNELS*8-1:0] own_scaling,
  input wire logic [CHANNELS*12-1:0] own_bright,
  // to the dimming and breathing engines
  output logic pattern_enable,
  output lgsc_pkg::lgsc_byte_t fade_max,
  output lgsc_pkg::lgsc_byte_t fade_min,
  output logic [CHANNELS*8-1:0] channel_colour_scaling,
  output logic [CHANNELS*12-1:0] channel_brightness,
  output logic [CHANNELS*2-1:0] channel_mode
);
  import lgsc_pkg::*;

  // =====================================================
  // registers
  lgsc_byte_t red_group_scaling;
  lgsc_byte_t green_group_scaling;
  lgsc_byte_t blue_group_scaling;
  lgsc_byte_t group_configuration;
  lgsc_byte_t pattern_configuration;
  lgsc_byte_t group_brightness_high;
  lgsc_byte_t group_brightness_low;
  lgsc_byte_t next_red_group_scaling;
  lgsc_byte_t next_green_group_scaling;
  lgsc_byte_t next_blue_group_scaling;
  lgsc_byte_t next_group_configuration;
  lgsc_byte_t next_pattern_configuration;
  lgsc_byte_t next_group_brightness_high;
  lgsc_byte_t next_group_brightness_low;
  lgsc_byte_t next_reg_rdata;

  function automatic lgsc_byte_t lgsc_read(input lgsc_byte_t a);
    case (a)
      `LGSC_PATTERN_CONFIGURATION_ADDR: lgsc_read = pattern_configuration;
      `LGSC_GROUP_BRIGHTNESS_HIGH_ADDR: lgsc_read = group_brightness_high;
      `LGSC_GROUP_BRIGHTNESS_LOW_ADDR: lgsc_read = group_brightness_low;
      `LGSC_RED_GROUP_SCALING_ADDR: lgsc_read = red_group_scaling;
      `LGSC_GREEN_GROUP_SCALING_ADDR: lgsc_read = green_group_scaling;
      `LGSC_BLUE_GROUP_SCALING_ADDR: lgsc_read = blue_group_scaling;
      `LGSC_GROUP_CONFIGURATION_ADDR: lgsc_read = group_configuration;
      default: lgsc_read = 8'h00;
    endcase
  endfunction

  // =====================================================
  // colour scaling group
  always_comb begin
    next_red_group_scaling = red_group_scaling;
    next_green_group_scaling = green_group_scaling;
    next_blue_group_scaling = blue_group_scaling;
    if (reg_wr) begin
      case (reg_addr)
        `LGSC_RED_GROUP_SCALING_ADDR: begin
          next_red_group_scaling = reg_wdata;
        end
        `LGSC_GREEN_GROUP_SCALING_ADDR: begin
          next_green_group_scaling = reg_wdata;
        end
        `LGSC_BLUE_GROUP_SCALING_ADDR: begin
          next_blue_group_scaling = reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      red_group_scaling <= `LGSC_SCALING_RST;
      green_group_scaling <= `LGSC_SCALING_RST;
      blue_group_scaling <= `LGSC_SCALING_RST;
    end else begin
      red_group_scaling <= next_red_group_scaling;
      green_group_scaling <= next_green_group_scaling;
      blue_group_scaling <= next_blue_group_scaling;
    end
  end

  // =====================================================
  // pattern configuration and group brightness
  always_comb begin
    next_pattern_configuration = pattern_configuration;
    next_group_brightness_high = group_brightness_high;
    next_group_brightness_low = group_brightness_low;
    if (reg_wr) begin
      case (reg_addr)
        `LGSC_PATTERN_CONFIGURATION_ADDR: begin
          // upper nibble is reserved and reads zero
          next_pattern_configuration = {4'h0, reg_wdata[3:0]};
        end
        `LGSC_GROUP_BRIGHTNESS_HIGH_ADDR: begin
          next_group_brightness_high = reg_wdata;
        end
        `LGSC_GROUP_BRIGHTNESS_LOW_ADDR: begin
          next_group_brightness_low = reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pattern_configuration <= `LGSC_PATTERN_CFG_RST;
      group_brightness_high <= `LGSC_BRIGHT_RST;
      group_brightness_low <= `LGSC_BRIGHT_RST;
    end else begin
      pattern_configuration <= next_pattern_configuration;
      group_brightness_high <= next_group_brightness_high;
      group_brightness_low <= next_group_brightness_low;
    end
  end

  // =====================================================
  // group configuration
  always_comb begin
    next_group_configuration = group_configuration;
    if (reg_wr && reg_addr == `LGSC_GROUP_CONFIGURATION_ADDR) begin
      // bits 5:3 are read-only zero
      next_group_configuration = reg_wdata & `LGSC_GROUP_CFG_WMASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      group_configuration <= `LGSC_GROUP_CFG_RST;
    end else begin
      group_configuration <= next_group_configuration;
    end
  end

  // =====================================================
  // read data, held until the next read
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      next_reg_rdata = lgsc_read(reg_addr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // =====================================================
  // group decode
  logic scaling_dis;
  lgsc_bright_t group_bright;
  lgsc_byte_t colour_scaling [3];

  always_comb begin
    pattern_enable = pattern_configuration[`LGSC_PATTERN_ENABLE_BIT];
    scaling_dis = group_configuration[`LGSC_GROUP_SCALING_DISABLE_BIT];
    group_bright = {group_brightness_high[3:0], group_brightness_low};
    fade_max = pattern_enable ? group_brightness_high : 8'h00;
    fade_min = pattern_enable ? group_brightness_low : 8'h00;
    colour_scaling[0] = red_group_scaling;
    colour_scaling[1] = green_group_scaling;
    colour_scaling[2] = blue_group_scaling;
  end

  // =====================================================
  // channels: triple = index / 3, colour = index % 3
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    lgsc_mode_e mode;
    lgsc_channel_select u_sel (
      .group_en(group_configuration[(i / 3) % 3]),
      .pattern_en(pattern_enable),
      .scaling_dis(scaling_dis),
      .shared_scaling(colour_scaling[i % 3]),
      .group_bright(group_bright),
      .own_scaling(own_scaling[i*8 +: 8]),
      .own_bright(own_bright[i*12 +: 12]),
      .mode(mode),
      .scaling(channel_colour_scaling[i*8 +: 8]),
      .bright(channel_brightness[i*12 +: 12])
    );
    assign channel_mode[i*2 +: 2] = mode;
  end
endmodule

// ==== bench/lgsc_chk.sv ====
`timescale 1ns/1ps
module lgsc_chk
  import lgsc_pkg::*;
#(
  parameter int CHANNELS = 9
)
(
  // clock, reset and register access
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire lgsc_pkg::lgsc_byte_t reg_addr,
  input wire lgsc_pkg::lgsc_byte_t reg_wdata,
  input wire lgsc_pkg::lgsc_byte_t reg_rdata,
  // channel settings and results
  input wire logic [CHANNELS*8-1:0] own_scaling,
  input wire logic [CHANNELS*12-1:0] own_bright,
  input wire logic pattern_enable,
  input wire lgsc_pkg::lgsc_byte_t fade_max,
  input wire lgsc_pkg::lgsc_byte_t fade_min,
  input wire logic [CHANNELS*8-1:0] channel_colour_scaling,
  input wire logic [CHANNELS*12-1:0] channel_brightness,
  input wire logic [CHANNELS*2-1:0] channel_mode
);
  // ==========================================
  // shadow of written bytes
  lgsc_byte_t sh [0:15];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) sh <= '{default: 8'h00};
    else if (reg_wr && reg_addr[7:4] == 4'h8) sh[reg_addr[3:0]] <= reg_wdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  chk_red_group: assert property (sh[11][0] && !sh[11][6] |->
    channel_colour_scaling[7:0] == sh[8]) else $error("red scaling");
  chk_green_group: assert property (sh[11][1] && !sh[11][6] |->
    channel_colour_scaling[39:32] == sh[9]) else $error("green scaling");
  chk_blue_group: assert property (sh[11][2] && !sh[11][6] |->
    channel_colour_scaling[71:64] == sh[10]) else $error("blue scaling");
  chk_own_scaling: assert property (sh[11][6] |->
    channel_colour_scaling[23:16] == own_scaling[23:16]) else $error("own");
  chk_group_mode: assert property (!sh[0][0] |->
    channel_mode[7:6] == {1'b0, sh[11][1]}) else $error("group mode");
  chk_breath_mode: assert property (sh[0][0] |-> pattern_enable &&
    channel_mode[17:16] == {sh[11][2], 1'b0}) else $error("breath mode");
  chk_group_bright: assert property (!sh[0][0] && sh[11][0] |->
    channel_brightness[11:0] == {sh[6][3:0], sh[7]}) else $error("bright");
  chk_fade_levels: assert property (sh[0][0] |->
    fade_max == sh[6] && fade_min == sh[7]) else $error("fade levels");
  chk_own_bright: assert property (!sh[11][2] |->
    channel_brightness[107:96] == own_bright[107:96]) else $error("own bright");
endmodule
bind lgsc_top lgsc_chk #(.CHANNELS(CHANNELS)) u_chk (.*);

// ==== bench/lgsc_host.sv ====
`timescale 1ns/1ps
module lgsc_host
  import lgsc_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register access
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output lgsc_pkg::lgsc_byte_t reg_addr = 8'h00,
  output lgsc_pkg::lgsc_byte_t reg_wdata = 8'h00
);
  // released address and data lines show the inverse of the last value, strobes drop to 0
  task automatic acc(input logic w, input lgsc_byte_t a, d);
    @(negedge ref_clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import lgsc_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic reg_wr, reg_rd;
  wire lgsc_byte_t reg_addr, reg_wdata;
  lgsc_byte_t reg_rdata, fade_max, fade_min;
  logic [71:0] own_scaling = '0, channel_colour_scaling;
  logic [107:0] own_bright = '0, channel_brightness;
  logic [17:0] channel_mode;
  logic pattern_enable;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  logic [31:0] rnd = 32'h4f12bec5;
  logic [7:0] m [0:12] = '{default: 8'h00};
  lgsc_top #(.CHANNELS(9)) u_lgsc_top (.*);
  lgsc_host host (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] msk(input int a);
    if (a == 0) return 8'h0f;
    if (a == 11) return 8'hc7;
    return (a > 5 && a < 11) ? 8'hff : 8'h00;
  endfunction
  task automatic check(input string n, input logic [11:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic outputs();
    logic [7:0] s;
    logic [11:0] b;
    logic p, en;
    p = m[0][0];
    check("pattern", pattern_enable, p);
    check("fade_max", fade_max, p ? m[6] : 8'h00);
    check("fade_min", fade_min, p ? m[7] : 8'h00);
    for (int ch = 0; ch < 9; ch++) begin
      en = m[11][ch / 3];
      s = (en && !m[11][6]) ? m[8 + ch % 3] : own_scaling[ch*8+:8];
      b = (en && !p) ? {m[6][3:0], m[7]} : own_bright[ch*12+:12];
      check("mode", channel_mode[ch*2+:2], en ? (p ? 2 : 1) : 0);
      check("scaling", channel_colour_scaling[ch*8+:8], s);
      check("bright", channel_brightness[ch*12+:12], b);
    end
  endtask
  task automatic rd_check(input int a);
    host.acc(1'b0, 8'h80 + 8'(a), 8'h00);
    @(negedge ref_clk);
    check("rdata", reg_rdata, m[a]);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int a = 0; a < 13; a++) rd_check(a);
    outputs();
    repeat (150) begin
      int a;
      rnd = lfsr(rnd);
      a = rnd[7:0] % 13;
      host.acc(1'b1, 8'h80 + 8'(a), rnd[15:8]);
      m[a] = rnd[15:8] & msk(a);
      own_scaling = {rnd, lfsr(rnd), rnd[7:0]};
      own_bright = {~rnd, rnd, rnd ^ 32'h5a5a5a5a, rnd[23:12]};
      @(negedge ref_clk);
      outputs();
      rd_check(rnd[21:16] % 13);
    end
    summarize();
  end
endmodule
